// File: short_term_read_cache_bench.sv
// Self-checking bench for the short term read cache.
// Assumes the target model in its own file; inputs change at the falling edge.
`timescale 1ns/1ps
module short_term_read_cache_bench;
    logic CLOCK = 1'b0, RST_N = 1'b0, CFG_WR = 1'b0, CFG_RD = 1'b0, BUS_CONV = 1'b0;
    logic REQ_VALID = 1'b0, REQ_DONE = 1'b0, RD_READY = 1'b0, go = 1'b0, rd_d = 1'b0, serving = 1'b0;
    logic [7:0] CFG_ADDR = 8'h00;
    logic [3:0] CFG_BE = 4'h0;
    logic [31:0] CFG_WDATA = 32'h0, REQ_ADDR = 32'h0, seed = 32'hD7C912DE;
    logic [31:0] CFG_RDATA, RD_DATA, PF_ADDR, PF_DATA;
    logic CFG_ACK, RD_VALID, PF_REQ, PF_VALID, PF_READY;
    logic [31:0] cfg_q[$], rd_q[$];
    int failures = 0, samples_checked = 0, cycles = 0, pops = 0, want = 0;

    strc_cache DUT (.CLOCK(CLOCK), .RST_N(RST_N), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
        .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
        .BUS_CONV(BUS_CONV), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_DONE(REQ_DONE),
        .RD_VALID(RD_VALID), .RD_READY(RD_READY), .RD_DATA(RD_DATA), .PF_REQ(PF_REQ), .PF_ADDR(PF_ADDR),
        .PF_VALID(PF_VALID), .PF_READY(PF_READY), .PF_DATA(PF_DATA));
    strc_target_model tgt (.clk(CLOCK), .rst_n(RST_N), .go(go), .pf_req(PF_REQ), .pf_ready(PF_READY),
        .pf_addr(PF_ADDR), .pf_valid(PF_VALID), .pf_data(PF_DATA));

    initial begin
        forever #5 CLOCK = ~CLOCK;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Result watcher: takes the oldest expectation whenever a result shows
    always @(posedge CLOCK) begin
        cycles++;
        if (rd_d) begin
            check("cfg_ack", 32'h1, {31'h0, CFG_ACK});
            check("cfg_rdata", cfg_q.pop_front(), CFG_RDATA);
        end
        rd_d = CFG_RD;
        if (RD_VALID && RD_READY) begin
            pops++;
            check("rd_data", rd_q.pop_front(), RD_DATA);
        end
        if (cycles > 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // Random pacing of the target and of the initiator's ready
    always @(negedge CLOCK) begin
        seed = xs(seed);
        go <= seed[0] | seed[1];
        RD_READY <= serving && (seed[2] | seed[3]) && pops < want;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge CLOCK);
    endtask

    // Read access expects d; write access stores d
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(negedge CLOCK);
        CFG_WR = wr;
        CFG_RD = !wr;
        CFG_ADDR = a;
        CFG_BE = 4'hF;
        CFG_WDATA = d;
        if (!wr) cfg_q.push_back(d);
        @(negedge CLOCK);
        CFG_WR = 1'b0;
        CFG_RD = 1'b0;
    endtask

    task automatic burst(input logic [31:0] a, input int n);
        int i;
        @(negedge CLOCK);
        REQ_ADDR = a;
        REQ_VALID = 1'b1;
        for (i = 0; i < n; i++) rd_q.push_back((a + 32'h4 * i) ^ 32'hC3C30F0F);
        want = pops + n;
        @(negedge CLOCK);
        REQ_VALID = 1'b0;
        serving = 1'b1;
        for (i = 0; i < 300 && pops < want; i++) @(negedge CLOCK);
        check("word_count", want, pops);
        serving = 1'b0;
        @(negedge CLOCK);
        REQ_DONE = 1'b1;
        @(negedge CLOCK);
        REQ_DONE = 1'b0;
    endtask

    initial begin
        repeat (5) @(posedge CLOCK);
        @(negedge CLOCK);
        RST_N = 1'b1;
        cfg(0, strc_pkg::OFS_SEC_BUF, 32'h0);
        cfg(0, strc_pkg::OFS_MISC2, 32'h0);
        cfg(0, 8'h44, 32'h0);
        cfg(1, strc_pkg::OFS_MISC2, 32'hFFFFFFFF);
        cfg(0, strc_pkg::OFS_MISC2, 32'h0000FFFF);
        cfg(1, strc_pkg::OFS_STATUS, 32'hFFFFFFFF);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        $display("test registers done");
        BUS_CONV = 1'b1;
        cfg(1, strc_pkg::OFS_SEC_BUF, 32'h70000000);
        cfg(1, strc_pkg::OFS_MISC2, 32'h0100);
        burst(32'h1000, 2);
        wait_n(20);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        $display("test retention off done");
        cfg(1, strc_pkg::OFS_MISC2, 32'h8100);
        cfg(1, strc_pkg::OFS_SEC_BUF, 32'h30000000);
        burst(32'h2000, 1);
        wait_n(20);
        cfg(0, strc_pkg::OFS_STATUS, 32'h404);
        check("pf_req", 32'h0, {31'h0, PF_REQ});
        check("pf_addr", 32'h2014, PF_ADDR);
        burst(32'h2004, 3);
        wait_n(100);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        $display("test hit done");
        burst(32'h3000, 1);
        wait_n(45);
        cfg(0, strc_pkg::OFS_STATUS, 32'h404);
        wait_n(30);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        $display("test timeout done");
        burst(32'h4000, 1);
        wait_n(20);
        burst(32'h5000, 2);
        cfg(1, strc_pkg::OFS_MISC2, 32'h0);
        wait_n(3);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        $display("test miss and disable done");
        cfg(1, strc_pkg::OFS_MISC2, 32'h8100);
        burst(32'h6000, 1);
        BUS_CONV = 1'b0;
        wait_n(4);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        burst(32'h6000, 1);
        wait_n(20);
        cfg(0, strc_pkg::OFS_STATUS, 32'h1);
        $display("test extended mode done");
        report_and_stop();
    end
endmodule

// File: strc_cache.sv
// Short term read cache: keeps prefetched read data after the initiator ends.
// Assumes request, done and prefetch strobes come from logic on CLOCK.
//
// Functional notes
// - Retention off: leftover prefetched data is dropped when the master finishes.
// - Retention works only while the secondary bus runs conventional PCI.
// - Retention needs both bit 8 and bit 15 of register B8h set.
// - Retention on: prefetched data is kept after the read completes.
// - Prefetching continues until the amount chosen by bits 30:28 at 40h.
// - A new request starting at the next undelivered held address is answered from the held data; any other address restarts.
// - Held data is dropped 64 clocks after partial return without new request.
// - Retention applies to every secondary device alike, no per-device choice.
// - A 64 dword configuration space holds the control registers.
`timescale 1ns/1ps
module strc_cache (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [strc_pkg::CFG_AW-1:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_ACK,
    input wire logic BUS_CONV,
    input wire logic REQ_VALID,
    input wire logic [strc_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic REQ_DONE,
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [strc_pkg::DATA_W-1:0] RD_DATA,
    output logic PF_REQ,
    output logic [strc_pkg::ADDR_W-1:0] PF_ADDR,
    input wire logic PF_VALID,
    output logic PF_READY,
    input wire logic [strc_pkg::DATA_W-1:0] PF_DATA
);
    localparam logic [6:0] HOLD_LAST = 7'(strc_pkg::HOLD_CYCLES - 1);

    typedef struct packed {
        strc_pkg::strc_state_type state;
        logic [31:0] sec_buf;
        logic [15:0] misc2;
        logic [31:0] cfg_rdata;
        logic cfg_ack;
        logic conv_meta;
        logic conv;
        logic [strc_pkg::ADDR_W-1:0] deliver_addr;
        logic [strc_pkg::ADDR_W-1:0] pf_addr;
        logic pf_req;
        logic [3:0] fill;
        logic [6:0] timer;
        logic returned;
    } strc_cache_state_type;

    strc_cache_state_type s;
    strc_cache_state_type next_s;
    strc_fifo_if #(.W(strc_pkg::DATA_W)) fq ();

    logic retain_on;
    logic [3:0] limit;
    logic push;
    logic pop;
    logic hit;

    strc_fifo #(.W(strc_pkg::DATA_W), .DEPTH(strc_pkg::FIFO_DEPTH)) u_fifo (
        .clk(CLOCK),
        .rst_n(RST_N),
        .f(fq.user)
    );

    // Mode pin is gated with both enable bits; no device number enters it
    assign retain_on = s.misc2[strc_pkg::MISC2_EN_LO] && s.misc2[strc_pkg::MISC2_EN_HI] && s.conv;
    assign limit = {1'b0, s.sec_buf[strc_pkg::PF_AMOUNT_LSB +: strc_pkg::PF_AMOUNT_W]} + 4'h1;
    assign push = PF_VALID && s.pf_req && fq.in_ready;
    assign pop = fq.out_valid && fq.out_ready;
    assign hit = REQ_VALID && (REQ_ADDR == s.deliver_addr);
    assign fq.in_valid = PF_VALID && s.pf_req;
    assign fq.in_data = PF_DATA;
    assign fq.out_ready = RD_READY && (s.state == strc_pkg::ST_SERVE);

    assign CFG_RDATA = s.cfg_rdata;
    assign CFG_ACK = s.cfg_ack;
    assign RD_VALID = fq.out_valid;
    assign RD_DATA = fq.out_data;
    assign PF_REQ = s.pf_req;
    assign PF_ADDR = s.pf_addr;
    assign PF_READY = fq.in_ready;

    always_comb begin
        next_s = s;
        fq.clear = 1'b0;
        next_s.conv_meta = BUS_CONV;
        next_s.conv = s.conv_meta;
        // Configuration port; all other dwords of the space read as zero
        next_s.cfg_ack = CFG_WR || CFG_RD;
        next_s.cfg_rdata = 32'h0;
        if (CFG_WR) begin
            for (int b = 0; b < 4; b++) begin
                if (CFG_BE[b] && CFG_ADDR == strc_pkg::OFS_SEC_BUF) begin
                    next_s.sec_buf[8*b +: 8] = CFG_WDATA[8*b +: 8];
                end
                if (CFG_BE[b] && b < 2 && CFG_ADDR == strc_pkg::OFS_MISC2) begin
                    next_s.misc2[8*b +: 8] = CFG_WDATA[8*b +: 8];
                end
            end
        end
        if (CFG_RD) begin
            case (CFG_ADDR)
                strc_pkg::OFS_SEC_BUF: next_s.cfg_rdata = s.sec_buf;
                strc_pkg::OFS_MISC2: next_s.cfg_rdata = {16'h0, s.misc2};
                strc_pkg::OFS_STATUS: next_s.cfg_rdata = {20'h0, s.fill, 5'h0, s.state};
                default: next_s.cfg_rdata = 32'h0;
            endcase
        end
        if (push) begin
            next_s.pf_addr = s.pf_addr + strc_pkg::WORD_STEP;
        end
        if (pop) begin
            next_s.deliver_addr = s.deliver_addr + strc_pkg::WORD_STEP;
            next_s.returned = 1'b1;
            next_s.timer = 7'h0;
        end
        next_s.fill = s.fill + {3'h0, push} - {3'h0, pop};
        case (s.state)
            strc_pkg::ST_IDLE: begin
                if (REQ_VALID) begin
                    next_s.state = strc_pkg::ST_SERVE;
                end
            end
            strc_pkg::ST_SERVE: begin
                if (REQ_DONE && retain_on) begin
                    next_s.state = strc_pkg::ST_HOLD;
                    next_s.timer = 7'h0;
                end else if (REQ_DONE) begin
                    next_s.state = strc_pkg::ST_IDLE;
                end
            end
            strc_pkg::ST_HOLD: begin
                if (!retain_on) begin
                    next_s.state = strc_pkg::ST_IDLE;
                end else if (hit) begin
                    next_s.state = strc_pkg::ST_SERVE;
                    next_s.timer = 7'h0;
                end else if (REQ_VALID) begin
                    next_s.state = strc_pkg::ST_SERVE;
                end else if (s.returned && s.timer == HOLD_LAST) begin
                    next_s.state = strc_pkg::ST_IDLE;
                end else if (s.returned) begin
                    next_s.timer = s.timer + 7'h1;
                end
            end
            default: next_s.state = strc_pkg::ST_IDLE;
        endcase
        // A miss restarts the stream at the new address; a stale word is not kept
        if (REQ_VALID && (s.state == strc_pkg::ST_IDLE || (s.state == strc_pkg::ST_HOLD && retain_on && !hit))) begin
            fq.clear = 1'b1;
            next_s.fill = 4'h0;
            next_s.deliver_addr = REQ_ADDR;
            next_s.pf_addr = REQ_ADDR;
            next_s.returned = 1'b0;
            next_s.timer = 7'h0;
        end
        if (next_s.state == strc_pkg::ST_IDLE) begin
            fq.clear = 1'b1;
            next_s.fill = 4'h0;
            next_s.returned = 1'b0;
        end
        next_s.pf_req = (next_s.state != strc_pkg::ST_IDLE) && (next_s.fill < limit);
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            s <= '0;
            s.state <= strc_pkg::ST_IDLE;
            s.sec_buf <= strc_pkg::SEC_BUF_RST;
            s.misc2 <= strc_pkg::MISC2_RST;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    property p_drop_when_off;
        s.state == strc_pkg::ST_SERVE && REQ_DONE && !retain_on |=> s.state == strc_pkg::ST_IDLE && s.fill == 4'h0;
    endproperty
    a_drop_when_off: assert property (p_drop_when_off) else $error("Data kept with retention off");
    property p_conv_only;
        s.state == strc_pkg::ST_HOLD && !s.conv |=> s.state == strc_pkg::ST_IDLE && !fq.out_valid;
    endproperty
    a_conv_only: assert property (p_conv_only) else $error("Held data outside conventional mode");
    property p_both_bits;
        s.state == strc_pkg::ST_HOLD && $past(s.state) == strc_pkg::ST_SERVE
            |-> $past(s.misc2[strc_pkg::MISC2_EN_LO] && s.misc2[strc_pkg::MISC2_EN_HI]);
    endproperty
    a_both_bits: assert property (p_both_bits) else $error("Hold entered without both enables");
    property p_keep_on_done;
        s.state == strc_pkg::ST_SERVE && REQ_DONE && retain_on |=> s.state == strc_pkg::ST_HOLD;
    endproperty
    a_keep_on_done: assert property (p_keep_on_done) else $error("Data not kept after completion");
    property p_pf_limit;
        s.pf_req |-> s.fill < $past(limit);
    endproperty
    a_pf_limit: assert property (p_pf_limit) else $error("Prefetch beyond selected amount");
    property p_hit_serves;
        s.state == strc_pkg::ST_HOLD && retain_on && hit ##1 fq.out_valid |-> s.state == strc_pkg::ST_SERVE && fq.out_valid;
    endproperty
    a_hit_serves: assert property (p_hit_serves) else $error("Held data not returned on hit");
    property p_expire;
        s.state == strc_pkg::ST_HOLD && retain_on && s.returned && s.timer == HOLD_LAST && !REQ_VALID
            |=> s.state == strc_pkg::ST_IDLE;
    endproperty
    a_expire: assert property (p_expire) else $error("Held data outlived the discard delay");
    property p_timer_bound;
        s.state == strc_pkg::ST_HOLD |-> s.timer <= HOLD_LAST;
    endproperty
    a_timer_bound: assert property (p_timer_bound) else $error("Discard timer overran");
    property p_any_device;
        s.state == strc_pkg::ST_HOLD && retain_on && REQ_VALID |=> s.state == strc_pkg::ST_SERVE;
    endproperty
    a_any_device: assert property (p_any_device) else $error("Request not accepted in hold");
    property p_cfg_unmapped;
        CFG_RD && CFG_ADDR != strc_pkg::OFS_SEC_BUF && CFG_ADDR != strc_pkg::OFS_MISC2
            && CFG_ADDR != strc_pkg::OFS_STATUS |=> CFG_ACK && CFG_RDATA == 32'h0;
    endproperty
    a_cfg_unmapped: assert property (p_cfg_unmapped) else $error("Unmapped dword not zero");
    property p_disable_clears;
        s.state == strc_pkg::ST_HOLD && !retain_on |=> s.fill == 4'h0 ##1 !fq.out_valid;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("Disable left held data");

    c_hold: cover property (s.state == strc_pkg::ST_SERVE ##1 s.state == strc_pkg::ST_HOLD);
    c_hit: cover property (s.state == strc_pkg::ST_HOLD && hit && retain_on);
    c_expire: cover property (s.state == strc_pkg::ST_HOLD ##1 s.state == strc_pkg::ST_IDLE && retain_on);
endmodule

// File: strc_fifo.sv
// Data FIFO with registered input ready and registered output stage.
// Assumes DEPTH is a power of two; clear drops every word at once.
`timescale 1ns/1ps
module strc_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    strc_fifo_if.store f
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] cnt;
        logic in_ready;
        logic out_valid;
        logic [W-1:0] out_data;
    } strc_fifo_state_type;

    strc_fifo_state_type s;
    strc_fifo_state_type next_s;

    assign f.in_ready = s.in_ready;
    assign f.out_valid = s.out_valid;
    assign f.out_data = s.out_data;

    always_comb begin
        next_s = s;
        if (f.clear) begin
            next_s.wptr = '0;
            next_s.rptr = '0;
            next_s.cnt = '0;
            next_s.out_valid = 1'b0;
            next_s.in_ready = 1'b1;
        end else begin
            if (!s.out_valid || f.out_ready) begin
                if (s.cnt != '0) begin
                    next_s.out_data = s.mem[s.rptr];
                    next_s.out_valid = 1'b1;
                    next_s.rptr = s.rptr + 1'b1;
                    next_s.cnt = next_s.cnt - 1'b1;
                end else begin
                    next_s.out_valid = 1'b0;
                end
            end
            if (f.in_valid && s.in_ready) begin
                next_s.mem[s.wptr] = f.in_data;
                next_s.wptr = s.wptr + 1'b1;
                next_s.cnt = next_s.cnt + 1'b1;
            end
            // Ready is a flop, so leave room for the word it admits next cycle
            next_s.in_ready = (next_s.cnt < FULL_CNT);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// File: strc_fifo_if.sv
// Carrier between the cache control and its data FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface strc_fifo_if #(parameter int W = 32);
    logic clear;
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport user (output clear, output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
    modport store (input clear, input in_valid, output in_ready, input in_data,
                   output out_valid, input out_ready, output out_data);
endinterface

// File: strc_pkg.sv
// Constants and types shared by the short term read cache files.
// Assumes a single secondary clock and a dword-wide data path.
package strc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CFG_AW = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [CFG_AW-1:0] OFS_SEC_BUF = 8'h40;
    localparam logic [CFG_AW-1:0] OFS_MISC2 = 8'hB8;
    localparam logic [CFG_AW-1:0] OFS_STATUS = 8'hBC;
    localparam int PF_AMOUNT_LSB = 28;
    localparam int PF_AMOUNT_W = 3;
    localparam int MISC2_EN_LO = 8;
    localparam int MISC2_EN_HI = 15;
    localparam logic [31:0] SEC_BUF_RST = 32'h0;
    localparam logic [15:0] MISC2_RST = 16'h0;
    // Discard delay, given in secondary clocks
    localparam int HOLD_TIME_CLK = 64;
    localparam int HOLD_CYCLES = HOLD_TIME_CLK;
    localparam logic [ADDR_W-1:0] WORD_STEP = 32'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SERVE = 3'b010,
        ST_HOLD = 3'b100
    } strc_state_type;
endpackage

// File: strc_target_model.sv
// Behavioural prefetch target facing the cache's prefetch link.
// Assumes the bench paces it through go; data is a fixed function of address.
`timescale 1ns/1ps
module strc_target_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic pf_req,
    input wire logic pf_ready,
    input wire logic [31:0] pf_addr,
    output logic pf_valid,
    output logic [31:0] pf_data
);
    // An offered word stays up until taken, so a stall never loses it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pf_valid <= 1'b0;
        end else if (pf_valid && pf_req && pf_ready) begin
            pf_valid <= go;
        end else if (!pf_valid) begin
            pf_valid <= go && pf_req;
        end
    end
    // Idle data is inverted so a stale word never looks valid
    assign pf_data = pf_valid ? (pf_addr ^ 32'hC3C30F0F) : ~(pf_addr ^ 32'hC3C30F0F);
endmodule
